// *** rcw_cfg.svh ***
// offsets, field positions, reset values and timing counts of the checksum/whitening slice
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RCW_OFF_PKT_CTL 12'h518
`define RCW_OFF_CRC_CFG 12'h534
`define RCW_OFF_CRC_GEN 12'h538
`define RCW_OFF_CRC_SEED 12'h53C
`define RCW_OFF_GAP 12'h544
`define RCW_OFF_RSSI 12'h548
`define RCW_OFF_STATE 12'h550
`define RCW_OFF_WSEED 12'h554
`define RCW_OFF_BCC 12'h560
`define RCW_OFF_DAB0 12'h600
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RCW_LEN_LSB 0
`define RCW_SKIP_BIT 8
`define RCW_WHITE_ON_BIT 25
`define RCW_WSEED_FIXED_BIT 6
`define RCW_WSEED_RST 7'h40
`define RCW_CRC_W 24
// ----------------------------------------
// timing
// ----------------------------------------
`define RCW_CLK_HZ 50000000
`define RCW_HZ_PER_MHZ 1000000
`define RCW_CYC_PER_US (`RCW_CLK_HZ / `RCW_HZ_PER_MHZ)
`endif

// *** rcw_pkg.sv ***
// types shared by the checksum/whitening slice
package rcw_pkg;
  // which packet field the current on-air bit belongs to
  typedef enum logic [1:0] {fld_none, fld_addr, fld_body, fld_crc} rcw_field_type;
  // interframe gap timer states
  typedef enum {gap_idle, gap_run} rcw_gap_state_type;
endpackage

// *** rcw_link_if.sv ***
// settings and bit stream passed from the register slice to its engines
`timescale 1ns/1ps
interface rcw_link_if;
  import rcw_pkg::*;
  logic [1:0] crc_len; // checksum bytes, 0 = off
  logic skip_addr; // address left out of checksum
  logic [23:0] crc_gen; // generator taps
  logic [23:0] crc_seed; // checksum preload
  logic white_on; // scrambler enable
  logic [6:0] white_seed; // scrambler seed, bit 6 forced
  logic tx_mode; // 1 transmit, 0 receive
  logic pkt_start; // one-cycle packet start
  logic bit_valid; // one on-air bit this cycle
  logic bit_data; // the bit
  rcw_field_type field; // field of the bit
  modport core (output crc_len, skip_addr, crc_gen, crc_seed, white_on, white_seed,
    tx_mode, pkt_start, bit_valid, bit_data, field);
  modport crc (input crc_len, skip_addr, crc_gen, crc_seed, tx_mode, pkt_start,
    bit_valid, bit_data, field);
  modport white (input white_on, white_seed, pkt_start, bit_valid, bit_data, field);
endinterface

// *** rcw_crc.sv ***
// bit-serial checksum engine with programmable taps and width
`include "rcw_cfg.svh"
`timescale 1ns/1ps
module rcw_crc
  import rcw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings and bits
  rcw_link_if.crc lnk,
  // results
  output logic tx_crc_bit,
  output logic crc_ok
);
  // width mask for the selected byte count
  function automatic logic [23:0] len_mask(input logic [1:0] len);
    unique case (len)
      2'h0: len_mask = 24'h000000;
      2'h1: len_mask = 24'h0000FF;
      2'h2: len_mask = 24'h00FFFF;
      2'h3: len_mask = 24'hFFFFFF;
    endcase
  endfunction
  // top bit of the selected width
  function automatic logic [23:0] len_top(input logic [1:0] len);
    len_top = len_mask(len) ^ (len_mask(len) >> 1);
  endfunction

  logic [23:0] crc_reg; // shift register
  logic [23:0] crc_next; // its next value
  logic top_bit; // current outgoing bit
  logic fb; // feedback bit
  logic covered; // bit goes into checksum
  logic ckbit; // bit is a checksum bit

  // ----------------------------------------
  // next-state arithmetic
  // ----------------------------------------
  always_comb begin
    top_bit = |(crc_reg & len_top(lnk.crc_len));
    fb = lnk.bit_data ^ top_bit;
    // no checksum work at all when length is zero
    covered = lnk.bit_valid && (lnk.crc_len != 2'h0) &&
      ((lnk.field == fld_body) || ((lnk.field == fld_addr) && !lnk.skip_addr));
    ckbit = lnk.bit_valid && (lnk.crc_len != 2'h0) && (lnk.field == fld_crc);
    crc_next = crc_reg;
    if (lnk.crc_len == 2'h0) begin
      // checksum off: held at zero, nothing is computed
      crc_next = 24'h000000;
    end else if (lnk.pkt_start) begin
      // preload before any covered bit
      crc_next = lnk.crc_seed & len_mask(lnk.crc_len);
    end else if (covered) begin
      // taps from generator bits, constant term forced
      crc_next = ((crc_reg << 1) ^ (fb ? (lnk.crc_gen | 24'h000001) : 24'h000000))
        & len_mask(lnk.crc_len);
    end else if (ckbit) begin
      // checksum bits leave msb first
      crc_next = (crc_reg << 1) & len_mask(lnk.crc_len);
    end
  end

  // ----------------------------------------
  // shift register and transmit bit
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= 24'h000000;
      tx_crc_bit <= 1'b0;
    end else begin
      crc_reg <= crc_next;
      tx_crc_bit <= |(crc_next & len_top(lnk.crc_len));
    end
  end

  // ----------------------------------------
  // receive compare
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ok <= 1'b1;
    end else if (lnk.pkt_start) begin
      crc_ok <= 1'b1;
    end else if (ckbit && !lnk.tx_mode && (lnk.bit_data != top_bit)) begin
      crc_ok <= 1'b0;
    end
  end

  property p_seed_load;
    @(posedge pclk) disable iff (!presetn)
    lnk.pkt_start |=> crc_reg == ($past(lnk.crc_seed) & len_mask($past(lnk.crc_len)));
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("seed not preloaded");
  property p_off_idle;
    @(posedge pclk) disable iff (!presetn)
    (lnk.crc_len == 2'h0) |=> crc_reg == 24'h000000;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("checksum runs while off");
  property p_skip;
    @(posedge pclk) disable iff (!presetn)
    (lnk.bit_valid && lnk.skip_addr && lnk.field == fld_addr && !lnk.pkt_start)
      |=> $stable(crc_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("address bit entered checksum");
endmodule

// *** rcw_white.sv ***
// seven-bit data scrambler
`include "rcw_cfg.svh"
`timescale 1ns/1ps
module rcw_white
  import rcw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings and bits
  rcw_link_if.white lnk,
  // scrambled stream
  output logic white_bit,
  output logic white_valid
);
  logic [6:0] lfsr_reg; // scrambler state, index = position
  logic scramble; // this bit is scrambled

  always_comb begin
    scramble = lnk.white_on && lnk.bit_valid && (lnk.field != fld_addr) &&
      (lnk.field != fld_none);
  end

  // ----------------------------------------
  // scrambler state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_lfsr_rst: lfsr_reg <= 7'h01;
    end else if (lnk.pkt_start) begin
      // seed bit i goes to position 6-i
      for (int i = 0; i < 7; i++) begin
        lfsr_reg[6 - i] <= lnk.white_seed[i];
      end
    end else if (scramble) begin
      lfsr_reg <= {lfsr_reg[5], lfsr_reg[4], lfsr_reg[3] ^ lfsr_reg[6], lfsr_reg[2:0],
        lfsr_reg[6]};
    end
  end

  // ----------------------------------------
  // output bit
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      white_bit <= 1'b0;
      white_valid <= 1'b0;
    end else begin
      white_valid <= lnk.bit_valid;
      white_bit <= lnk.bit_data ^ (scramble & lfsr_reg[6]);
    end
  end

  property p_pass;
    @(posedge pclk) disable iff (!presetn)
    (lnk.bit_valid && !lnk.white_on) |=> white_valid && white_bit == $past(lnk.bit_data);
  endproperty
  a_pass: assert property (p_pass) else $error("bit altered with scrambler off");
  property p_rev;
    @(posedge pclk) disable iff (!presetn)
    lnk.pkt_start |=> lfsr_reg[0] == $past(lnk.white_seed[6]) &&
      lfsr_reg[6] == $past(lnk.white_seed[0]);
  endproperty
  a_rev: assert property (p_rev) else $error("seed not reversed");
endmodule

// *** rcw_top.sv ***
// APB register slice for checksum, whitening, gap and radio status
`include "rcw_cfg.svh"
`timescale 1ns/1ps
module rcw_top
  import rcw_pkg::*;
#(
  parameter int GAP_W = 10, // interframe gap field width
  parameter int GAP_CNT_W = 16 // gap cycle counter width
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // packet bit stream from the radio core
  input wire logic pkt_start,
  input wire logic pkt_end,
  input wire logic tx_mode,
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire rcw_field_type bit_field,
  // radio status to show
  input wire logic [6:0] rssi_in,
  input wire logic [3:0] state_in,
  // engine results
  output logic tx_crc_bit,
  output logic crc_ok,
  output logic white_bit,
  output logic white_valid,
  output logic gap_done,
  // settings used by later stages
  output logic [31:0] bit_count_compare,
  output logic [31:0] peer_address_base_0
);
  localparam logic [GAP_CNT_W-1:0] CYC_US = GAP_CNT_W'(`RCW_CYC_PER_US);
  localparam logic [6:0] WSEED_RST = `RCW_WSEED_RST; // full seed reset, bit 6 implied

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0] crc_len_reg; // checksum byte count
  logic skip_reg; // address skip setting
  logic [23:0] gen_reg; // generator bits
  logic [23:0] seed_reg; // checksum seed
  logic [GAP_W-1:0] gap_reg; // interframe gap in us
  logic [6:0] rssi_reg; // signal strength sample
  logic [3:0] state_reg; // radio state sample
  logic [5:0] wseed_reg; // whitening seed bits 5..0
  logic white_on_reg; // whitening enable
  logic [GAP_CNT_W-1:0] gap_cnt_reg; // gap countdown
  rcw_gap_state_type gap_st_reg; // gap timer state

  logic setup_ph; // apb setup phase
  logic done_ph; // apb access completes this edge
  logic [32:0] rd_word; // {hit, data}

  // read mux and decode; returns hit flag above data
  function automatic logic [32:0] read_map(input logic [11:0] a);
    logic [31:0] d;
    logic hit;
    d = 32'h00000000;
    hit = 1'b1;
    unique case (a)
      `RCW_OFF_PKT_CTL: d[`RCW_WHITE_ON_BIT] = white_on_reg;
      `RCW_OFF_CRC_CFG: begin
        d[`RCW_LEN_LSB +: 2] = crc_len_reg;
        d[`RCW_SKIP_BIT] = skip_reg;
      end
      `RCW_OFF_CRC_GEN: d[23:0] = gen_reg;
      `RCW_OFF_CRC_SEED: d[23:0] = seed_reg;
      `RCW_OFF_GAP: d[GAP_W-1:0] = gap_reg;
      `RCW_OFF_RSSI: d[6:0] = rssi_reg;
      `RCW_OFF_STATE: d[3:0] = state_reg;
      // fixed bit always reads one
      `RCW_OFF_WSEED: d[6:0] = {1'b1, wseed_reg};
      `RCW_OFF_BCC: d = bit_count_compare;
      `RCW_OFF_DAB0: d = peer_address_base_0;
      default: hit = 1'b0;
    endcase
    read_map = {hit, d};
  endfunction

  always_comb begin
    setup_ph = psel && !penable;
    done_ph = psel && penable && pready;
    rd_word = read_map(paddr);
  end

  // ----------------------------------------
  // apb answer: one wait state in access
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        // unaligned or unmapped words answer with error
        prdata <= (pwrite || !rd_word[32]) ? 32'h00000000 : rd_word[31:0];
        pslverr <= !rd_word[32] || (paddr[1:0] != 2'h0);
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_len_reg <= 2'h0;
      skip_reg <= 1'b0;
      gen_reg <= 24'h000000;
      seed_reg <= 24'h000000;
      gap_reg <= '0;
      wseed_reg <= WSEED_RST[5:0];
      white_on_reg <= 1'b0;
      bit_count_compare <= 32'h00000000;
      peer_address_base_0 <= 32'h00000000;
    end else if (done_ph && pwrite && !pslverr) begin
      unique case (paddr)
        `RCW_OFF_PKT_CTL: white_on_reg <= pwdata[`RCW_WHITE_ON_BIT];
        `RCW_OFF_CRC_CFG: begin
          crc_len_reg <= pwdata[`RCW_LEN_LSB +: 2];
          skip_reg <= pwdata[`RCW_SKIP_BIT];
        end
        `RCW_OFF_CRC_GEN: gen_reg <= pwdata[23:0];
        `RCW_OFF_CRC_SEED: seed_reg <= pwdata[23:0];
        `RCW_OFF_GAP: gap_reg <= pwdata[GAP_W-1:0];
        // bit 6 is not stored, writes of zero have no effect
        `RCW_OFF_WSEED: wseed_reg <= pwdata[5:0];
        `RCW_OFF_BCC: bit_count_compare <= pwdata;
        `RCW_OFF_DAB0: peer_address_base_0 <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // status samples
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rssi_reg <= 7'h00;
      state_reg <= 4'h0;
    end else begin
      rssi_reg <= rssi_in;
      state_reg <= state_in;
    end
  end

  // ----------------------------------------
  // interframe gap timer, one tick per clock
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_st_reg <= gap_idle;
      gap_cnt_reg <= '0;
      gap_done <= 1'b0;
    end else begin
      gap_done <= 1'b0;
      unique case (gap_st_reg)
        gap_idle: begin
          if (pkt_end) begin
            // gap from last bit end to next first bit
            gap_cnt_reg <= GAP_CNT_W'(gap_reg) * CYC_US;
            gap_st_reg <= gap_run;
          end
        end
        gap_run: begin
          if (gap_cnt_reg <= GAP_CNT_W'(1)) begin
            gap_done <= 1'b1;
            gap_st_reg <= gap_idle;
          end else begin
            gap_cnt_reg <= gap_cnt_reg - GAP_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // engines
  // ----------------------------------------
  rcw_link_if lnk ();
  assign lnk.crc_len = crc_len_reg;
  assign lnk.skip_addr = skip_reg;
  assign lnk.crc_gen = gen_reg;
  assign lnk.crc_seed = seed_reg;
  assign lnk.white_on = white_on_reg;
  assign lnk.white_seed = {1'b1, wseed_reg};
  assign lnk.tx_mode = tx_mode;
  assign lnk.pkt_start = pkt_start;
  assign lnk.bit_valid = bit_valid;
  assign lnk.bit_data = bit_data;
  assign lnk.field = bit_field;

  rcw_crc u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.crc),
    .tx_crc_bit(tx_crc_bit),
    .crc_ok(crc_ok)
  );

  rcw_white u_white (
    .pclk(pclk),
    .presetn(presetn),
    .lnk(lnk.white),
    .white_bit(white_bit),
    .white_valid(white_valid)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wseed_one;
    @(posedge pclk) disable iff (!presetn)
    (done_ph && !pwrite && paddr == `RCW_OFF_WSEED) |-> prdata[6];
  endproperty
  a_wseed_one: assert property (p_wseed_one) else $error("seed bit 6 read zero");
  property p_len_write;
    @(posedge pclk) disable iff (!presetn)
    (done_ph && pwrite && !pslverr && paddr == `RCW_OFF_CRC_CFG)
      |=> crc_len_reg == $past(pwdata[1:0]) && skip_reg == $past(pwdata[8]);
  endproperty
  a_len_write: assert property (p_len_write) else $error("config not stored");
  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph ##1 (psel && penable)) |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer not one wait");
  property p_gap_zero;
    @(posedge pclk) disable iff (!presetn)
    (pkt_end && gap_st_reg == gap_idle && gap_reg == '0) |-> ##2 gap_done;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("zero gap late");
  property p_gap_one;
    @(posedge pclk) disable iff (!presetn)
    (pkt_end && gap_st_reg == gap_idle && gap_reg == GAP_W'(1))
      |-> ##51 gap_done;
  endproperty
  a_gap_one: assert property (p_gap_one) else $error("one us gap wrong length");

  // edges spent by the timer in its run state, for the length check
  logic [GAP_CNT_W-1:0] gap_age_reg;
  // counts while the timer runs, parks at zero when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_age_reg <= '0;
    end else if (gap_st_reg == gap_run) begin
      gap_age_reg <= gap_age_reg + GAP_CNT_W'(1);
    end else begin
      gap_age_reg <= '0;
    end
  end
  // the pulse comes after exactly max(1, gap * cycles per us) run edges
  property p_gap_len;
    @(posedge pclk) disable iff (!presetn)
    gap_done |-> gap_age_reg ==
      ((gap_reg == '0) ? GAP_CNT_W'(1) : GAP_CNT_W'(gap_reg) * CYC_US);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap pulse at wrong count");
  // a packet end while the timer runs must not restart or stop it
  property p_gap_busy;
    @(posedge pclk) disable iff (!presetn)
    (pkt_end && gap_st_reg == gap_run && gap_cnt_reg > GAP_CNT_W'(1))
      |=> gap_st_reg == gap_run;
  endproperty
  a_gap_busy: assert property (p_gap_busy) else $error("gap timer disturbed");
  property p_gen_bit0;
    @(posedge pclk) disable iff (!presetn)
    (done_ph && pwrite && !pslverr && paddr == `RCW_OFF_CRC_GEN)
      |=> gen_reg == $past(pwdata[23:0]);
  endproperty
  a_gen_bit0: assert property (p_gen_bit0) else $error("generator not stored");
  // outside the answer cycle the bus outputs stay quiet
  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> !pslverr && prdata == 32'h00000000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus output outside answer");
endmodule

// *** rcw_top_tb.sv ***
// self-checking bench for the checksum and whitening register slice
`timescale 1ns/1ps
`include "rcw_cfg.svh"
module rcw_top_tb
  import rcw_pkg::*;
;
  // ----------------------------------------
  // signals and reference state
  // ----------------------------------------
  localparam int GAP_W = 10; // gap field width handed to the design
  localparam logic [15:0] ADDR_V = 16'hA53C; // address field sent on air
  logic pclk = 1'b0; // bus clock
  logic presetn = 1'b0; // reset, held low at start
  logic psel = 1'b0; // apb request
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pkt_start = 1'b0; // packet stream drive
  logic pkt_end = 1'b0;
  logic tx_mode = 1'b0;
  logic bit_valid = 1'b0;
  logic bit_data = 1'b0;
  rcw_field_type bit_field = fld_none;
  logic [6:0] rssi_in = 7'h2A; // status shown read-only
  logic [3:0] state_in = 4'h9;
  logic tx_crc_bit; // engine results
  logic crc_ok;
  logic white_bit;
  logic white_valid;
  logic gap_done;
  logic [31:0] bit_count_compare;
  logic [31:0] peer_address_base_0;
  int num_errors = 0; // mismatches seen
  int n_tests = 0; // comparisons made
  int cyc = 0; // cycles run, for the hang limit
  logic [31:0] rd; // last read data
  logic err; // last error response
  logic [1:0] len_m; // model settings
  logic skip_m;
  logic [23:0] gen_m;
  logic [23:0] seed_m;
  logic wht_m;
  logic [6:0] ws_m = 7'h40;
  logic [23:0] crc_m; // model checksum
  logic [6:0] wl_m; // model scrambler positions
  logic ok_m; // model checksum verdict
  // register offsets, reset values and all-ones readback values
  logic [11:0] offs [0:7] = '{`RCW_OFF_PKT_CTL, `RCW_OFF_CRC_CFG, `RCW_OFF_CRC_GEN,
    `RCW_OFF_CRC_SEED, `RCW_OFF_GAP, `RCW_OFF_WSEED, `RCW_OFF_BCC, `RCW_OFF_DAB0};
  logic [31:0] rst_v [0:7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h40, 32'h0, 32'h0};
  logic [31:0] ones_v [0:7] = '{32'h02000000, 32'h103, 32'hFFFFFF, 32'hFFFFFF, 32'h3FF,
    32'h7F, 32'hFFFFFFFF, 32'hFFFFFFFF};
  // generators with bit zero written as zero
  logic [23:0] gens [0:3] = '{24'h0, 24'h18C, 24'h11020, 24'h65A};
  // ----------------------------------------
  // design and clock
  // ----------------------------------------
  rcw_top #(.GAP_W(GAP_W), .GAP_CNT_W(16)) u_rcw_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_start(pkt_start),
    .pkt_end(pkt_end), .tx_mode(tx_mode), .bit_valid(bit_valid), .bit_data(bit_data),
    .bit_field(bit_field), .rssi_in(rssi_in), .state_in(state_in),
    .tx_crc_bit(tx_crc_bit), .crc_ok(crc_ok), .white_bit(white_bit),
    .white_valid(white_valid), .gap_done(gap_done),
    .bit_count_compare(bit_count_compare), .peer_address_base_0(peer_address_base_0));
  // free-running bus clock
  initial begin
    forever #10 pclk = ~pclk;
  end
  // hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // verdict and end of run
  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, waits for pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // a transfer just released: let its idle edge pass first
    if (psel === 1'b1) @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the hang limit ends a lost one
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // checksum mask for a byte count
  function automatic logic [23:0] msk(input logic [1:0] l);
    return (24'h1 << (8 * l)) - 24'h1;
  endfunction
  // bit the model expects at the checksum output
  function automatic logic top_m();
    return (len_m == 2'd0) ? 1'b0 : crc_m[8*len_m-1];
  endfunction
  // program checksum and whitening settings
  task automatic cfg(input logic [1:0] len, input logic skip, input logic [23:0] gen,
    input logic [23:0] seed, input logic wht, input logic tx);
    len_m = len;
    skip_m = skip;
    gen_m = gen;
    seed_m = seed;
    wht_m = wht;
    tx_mode <= tx;
    apb(1'b1, `RCW_OFF_CRC_CFG, {23'h0, skip, 6'h0, len});
    apb(1'b1, `RCW_OFF_CRC_GEN, {8'h0, gen});
    apb(1'b1, `RCW_OFF_CRC_SEED, {8'h0, seed});
    apb(1'b1, `RCW_OFF_PKT_CTL, {6'h0, wht, 25'h0});
  endtask
  // packet start preloads checksum and scrambler
  task automatic start_pkt();
    pkt_start <= 1'b1;
    crc_m = seed_m & msk(len_m);
    wl_m = {<<{ws_m | 7'h40}};
    ok_m = 1'b1;
    @(posedge pclk);
    pkt_start <= 1'b0;
    @(negedge pclk);
    check("tx_crc_bit at start", top_m(), tx_crc_bit);
    @(posedge pclk);
  endtask
  // one on-air bit, then compare scrambler and checksum outputs
  task automatic send_bit(input logic b, input rcw_field_type f);
    logic ew;
    logic fb;
    int w;
    w = 8 * len_m;
    ew = b;
    bit_valid <= 1'b1;
    bit_data <= b;
    bit_field <= f;
    // address bits pass unscrambled
    if (wht_m && f != fld_addr) begin
      ew = b ^ wl_m[6];
      wl_m = {wl_m[5:4], wl_m[3] ^ wl_m[6], wl_m[2:0], wl_m[6]};
    end
    // checksum field shifts out, covered bits feed back
    if (len_m != 2'd0 && f == fld_crc) begin
      if (!tx_mode && b !== crc_m[w-1]) ok_m = 1'b0;
      crc_m = (crc_m << 1) & msk(len_m);
    end else if (len_m != 2'd0 && (f == fld_body || !skip_m)) begin
      fb = crc_m[w-1] ^ b;
      crc_m = ((crc_m << 1) ^ (fb ? (gen_m | 24'h1) : 24'h0)) & msk(len_m);
    end
    @(posedge pclk);
    bit_valid <= 1'b0;
    @(negedge pclk);
    check("white_valid", 32'h1, white_valid);
    check("white_bit", ew, white_bit);
    check("tx_crc_bit", top_m(), tx_crc_bit);
    @(posedge pclk);
  endtask
  // whole packet, flip selects a corrupted checksum bit
  task automatic pkt(input logic [31:0] body, input int flip);
    int nb;
    nb = (len_m == 2'd0) ? 8 : 8 * len_m;
    start_pkt();
    for (int i = 15; i >= 0; i--) send_bit(ADDR_V[i], fld_addr);
    for (int i = 31; i >= 0; i--) send_bit(body[i], fld_body);
    for (int i = 0; i < nb; i++) send_bit(top_m() ^ (i == flip), fld_crc);
    @(negedge pclk);
    check("crc_ok", ok_m, crc_ok);
    @(posedge pclk);
  endtask
  // gap timer from pkt_end, optional second pulse while running
  task automatic gap_run(input logic [9:0] g, input int exp_n, input logic dbl);
    int n;
    apb(1'b1, `RCW_OFF_GAP, {22'h0, g});
    pkt_end <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      pkt_end <= dbl && n == 10;
      #1;
    end while (gap_done !== 1'b1 && n < 2000);
    check("gap cycles", exp_n, n - 1);
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then all-ones readback
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      check("reset value", rst_v[i], rd);
    end
    foreach (offs[i]) apb(1'b1, offs[i], 32'hFFFFFFFF);
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      check("readback", ones_v[i], rd);
    end
    check("bit_count_compare", 32'hFFFFFFFF, bit_count_compare);
    check("peer_address_base_0", 32'hFFFFFFFF, peer_address_base_0);
    // fixed whitening seed bit
    apb(1'b1, `RCW_OFF_WSEED, 32'h0);
    apb(1'b0, `RCW_OFF_WSEED, 32'h0);
    check("whitening seed", 32'h40, rd);
    // read-only status and refused addresses
    apb(1'b1, `RCW_OFF_RSSI, 32'hFFFFFFFF);
    apb(1'b0, `RCW_OFF_RSSI, 32'h0);
    check("signal strength", {25'h0, rssi_in}, rd);
    apb(1'b0, `RCW_OFF_STATE, 32'h0);
    check("radio state", {28'h0, state_in}, rd);
    apb(1'b1, 12'h700, 32'hFFFFFFFF);
    check("unmapped pslverr", 32'h1, err);
    apb(1'b0, 12'h535, 32'h0);
    check("unaligned pslverr", 32'h1, err);
    check("unaligned prdata", 32'h0, rd);
    // every checksum width on transmit, address skipped or covered
    for (int l = 1; l <= 3; l++) begin
      cfg(l[1:0], l[0], gens[l], 24'hC3A5F1, 1'b0, 1'b1);
      pkt(32'h1234ABCD, -1);
    end
    // receive, good then corrupted checksum
    cfg(2'd2, 1'b0, gens[2], 24'h00FFFF, 1'b0, 1'b0);
    pkt(32'h5A5AC3C3, -1);
    pkt(32'h5A5AC3C3, 5);
    // zero length: no checksum at all
    cfg(2'd0, 1'b0, gens[1], 24'h0000AA, 1'b0, 1'b0);
    pkt(32'h0F0F0F0F, 3);
    // whitening on, then off
    apb(1'b1, `RCW_OFF_WSEED, 32'h25);
    ws_m = 7'h25;
    for (int w = 1; w >= 0; w--) begin
      cfg(2'd1, 1'b0, gens[1], 24'h0, w[0], 1'b1);
      start_pkt();
      for (int i = 31; i >= 0; i--) send_bit(ADDR_V[i % 16] ^ i[0], fld_body);
    end
    // interframe gap in microseconds
    gap_run(10'd0, 1, 1'b0);
    gap_run(10'd1, 50, 1'b0);
    gap_run(10'd3, 150, 1'b1);
    give_verdict();
  end
endmodule
